// [core/poe_ctl_pkg.sv]
// Constants for the port control write register bank.
// Assumes a byte-wide register write port fed by the serial management front end.
package poe_ctl_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int NUM_PORTS = 4;
	localparam logic [3:0] SEL_COMMON_CONTROL = 4'h1;
	localparam logic [3:0] SEL_PORT_FUNCTION = 4'h2;
	localparam logic [3:0] SEL_PORT_ENABLE_CONV = 4'h3;
	localparam logic [3:0] SEL_TEST_OVERRIDE = 4'hF;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Command byte fields.
	localparam int CMD_SEL_LSB = 3;
	localparam int CMD_PORT_LSB = 0;
	// Test register bits.
	localparam int TST_TSD_FORCE = 6;
	localparam int TST_POR_HOLD = 5;
	localparam int TST_DISC_TMR_OFF = 4;
	localparam int TST_DISC_HALT = 3;
	localparam int TST_DC_TMR_ZERO = 2;
	localparam int TST_ERR_TMR_OFF = 1;
	localparam logic [7:0] TST_MASK = 8'h7E;
	// Common control bits.
	localparam int CC_TSD_DISABLE = 5;
	localparam int CC_AC_HIGH = 4;
	localparam int CC_AC_LOW = 3;
	localparam int CC_UVOV_DISABLE = 2;
	localparam int CC_ALL_OFF = 1;
	localparam int CC_SW_RESET = 0;
	localparam logic [7:0] CC_MASK = 8'h3E;
	// Port function register bits.
	localparam int PF_DISC_FAULT_OFF = 5;
	localparam int PF_DC_DISC_OFF = 4;
	localparam logic [7:0] PF_MASK = 8'h3F;
	// Port enable and converter register bits.
	localparam int PE_PORT_DISABLE = 4;
	localparam int PE_CONV_START = 3;
	localparam int PE_CONV_ABORT = 2;
	localparam logic [7:0] PE_MASK = 8'h14;
	// Timings.
	localparam int DISC_PHASE_MS = 4;
	localparam int DC_DISC_MIN_MS = 300;
	localparam int DC_DISC_MAX_MS = 400;
	localparam int ERR_DELAY_MS = 750;
	localparam int POR_TIME_US = 100;
	localparam int POR_CYCLES = POR_TIME_US * (CLK_HZ / 1_000_000);
	// Port function codes; legacy detection shares the ramp-up code as printed.
	typedef enum logic [3:0] {
		FN_DISABLE      = 4'h0,
		FN_DISCOVERY_1  = 4'h1,
		FN_DISCOVERY_2  = 4'h2,
		FN_VOLT_SAMPLE  = 4'h3,
		FN_CLASSIFY     = 4'h5,
		FN_RAMP_UP      = 4'h6,
		FN_CONT_SAMPLE  = 4'h7,
		FN_RAMP_DOWN    = 4'h8,
		FN_AC_LOW       = 4'h9,
		FN_AC_HIGH      = 4'hA,
		FN_CURR_SAMPLE  = 4'hB,
		FN_TEMP_SAMPLE  = 4'hC
	} port_fn_t;
	localparam logic [3:0] FN_LEGACY = 4'h6;
	typedef enum logic [1:0] {
		POR_ACTIVE = 2'b00,
		POR_DONE   = 2'b01
	} por_state_t;
endpackage

// [core/poe_por_timer.sv]
// Power-on-reset timing cycle for the control bank.
// Assumes a single clock; restart is a one-cycle pulse from the register bank.
`timescale 1ns/1ns
`default_nettype none
module poe_por_timer #(
	parameter int CYCLES = poe_ctl_pkg::POR_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	input  wire logic i_restart,
	input  wire logic i_hold_off,
	output logic      o_in_reset
);
	localparam int CW = $clog2(CYCLES + 1);
	poe_ctl_pkg::por_state_t state_r;
	logic [CW-1:0]           cnt_r;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= poe_ctl_pkg::POR_ACTIVE;
			cnt_r   <= '0;
		end else if (i_restart) begin
			state_r <= poe_ctl_pkg::POR_ACTIVE;
			cnt_r   <= '0;
		end else begin
			unique case (state_r)
				poe_ctl_pkg::POR_ACTIVE: begin
					// Hold-off forces the timer straight to the non-reset state.
					if (i_hold_off || cnt_r == CW'(CYCLES - 1)) begin
						state_r <= poe_ctl_pkg::POR_DONE;
					end else begin
						cnt_r <= cnt_r + CW'(1);
					end
				end
				poe_ctl_pkg::POR_DONE: begin
					cnt_r <= '0;
				end
				default: begin
					state_r <= poe_ctl_pkg::POR_ACTIVE;
				end
			endcase
		end
	end

	assign o_in_reset = (state_r == poe_ctl_pkg::POR_ACTIVE);
endmodule
`default_nettype wire

// [core/poe_port_control_write_regs.sv]
// Write-side control register bank for a four-port power-sourcing manager.
// Assumes the serial front end delivers a command byte and a data byte with a write strobe.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Test bit 6 forces thermal shutdown, all ports off.
// - Test bit 5 holds power-on-reset logic out of reset.
// - Test bit 4 clear: 4 ms discovery timers; set: timers disabled.
// - Test bit 3 halts both discovery phases on all ports.
// - Test bit 2 zeroes the 300-400 ms DC disconnect timer.
// - Test bit 1 disables the 750 ms error-delay timer.
// - Common bit 5 disables thermal fault; locked after device probe.
// - Common bit 4 drives the high-side AC disconnect output.
// - Common bit 3 drives the low-side AC disconnect output.
// - Common bit 2 disables port over and under voltage faults.
// - Common bit 1 shuts all ports down at once, no ramp.
// - Common bit 0 resets everything and restarts power-on timing.
// - Both port registers exist per port, chosen by port address.
// - Port bit 5 suppresses signature resistance discovery faults.
// - Port bit 4 disables DC disconnect for AC disconnect use.
// - Function code zero powers down and resets the port.
// - Codes 1,2,3,5,6 start discovery, sampling, class, ramp up.
// - Codes 7 to C start sampling, ramp down, AC, current, temperature.
// - Second port register bit 4 disables the port.
// - Second port register bit 3 starts a conversion, self-clearing.
// - Second port register bit 2 aborts a running conversion.
// - Command bits 6-3 pick the register, bits 1-0 the port.
module poe_port_control_write_regs #(
	parameter int NUM_PORTS = poe_ctl_pkg::NUM_PORTS,
	parameter int POR_CYC   = poe_ctl_pkg::POR_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_arst_n,
	input  wire logic                   i_wr_stb,
	input  wire logic [7:0]             i_wr_cmd,
	input  wire logic [7:0]             i_wr_data,
	input  wire logic                   i_device_probed,
	output logic                        o_por_active,
	output logic                        o_thermal_shutdown_force,
	output logic                        o_disc_timer_disable,
	output logic                        o_disc_halt,
	output logic                        o_dc_disc_timer_zero,
	output logic                        o_error_delay_timer_disable,
	output logic                        o_thermal_shutdown_fault_disable,
	output logic                        o_ac_disconnect_high_drive,
	output logic                        o_ac_disconnect_low_drive,
	output logic                        o_uvov_fault_disable,
	output logic                        o_all_ports_off,
	output logic [NUM_PORTS-1:0]        o_port_off,
	output logic [NUM_PORTS*4-1:0]      o_port_function,
	output logic [NUM_PORTS-1:0]        o_function_start,
	output logic [NUM_PORTS-1:0]        o_disc_fault_disable,
	output logic [NUM_PORTS-1:0]        o_dc_disconnect_disable,
	output logic [NUM_PORTS-1:0]        o_port_disable,
	output logic [NUM_PORTS-1:0]        o_conv_start,
	output logic [NUM_PORTS-1:0]        o_conv_abort
);

////////////////////////////////////////////////////////////////////////////////
// Command decode.

	function automatic logic sel_is(input logic [7:0] cmd, input logic [3:0] code);
		return cmd[poe_ctl_pkg::CMD_SEL_LSB +: 4] == code;
	endfunction

	logic       wr_common;
	logic       wr_func;
	logic       wr_pen;
	logic       wr_test;
	logic [1:0] port_sel;
	logic       sw_reset;
	logic       clr;

	assign port_sel  = i_wr_cmd[poe_ctl_pkg::CMD_PORT_LSB +: 2];
	assign wr_common = i_wr_stb && sel_is(i_wr_cmd, poe_ctl_pkg::SEL_COMMON_CONTROL);
	assign wr_func   = i_wr_stb && sel_is(i_wr_cmd, poe_ctl_pkg::SEL_PORT_FUNCTION);
	assign wr_pen    = i_wr_stb && sel_is(i_wr_cmd, poe_ctl_pkg::SEL_PORT_ENABLE_CONV);
	assign wr_test   = i_wr_stb && sel_is(i_wr_cmd, poe_ctl_pkg::SEL_TEST_OVERRIDE);
	assign sw_reset  = wr_common && i_wr_data[poe_ctl_pkg::CC_SW_RESET];
	// Registers other than the test override stay cleared for the whole power-on timing cycle.
	assign clr       = sw_reset || o_por_active;

////////////////////////////////////////////////////////////////////////////////
// Power-on-reset timing.

	logic [7:0] test_r;

	poe_por_timer #(
		.CYCLES(POR_CYC)
	) u_por (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_restart (sw_reset),
		.i_hold_off(test_r[poe_ctl_pkg::TST_POR_HOLD]),
		.o_in_reset(o_por_active)
	);

////////////////////////////////////////////////////////////////////////////////
// Test override register. It survives the power-on cycle so that the hold
// bit can keep the timer out of reset; software reset still clears it.

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			test_r <= poe_ctl_pkg::RESET_VALUE;
		end else if (sw_reset) begin
			test_r <= poe_ctl_pkg::RESET_VALUE;
		end else if (wr_test) begin
			test_r <= i_wr_data & poe_ctl_pkg::TST_MASK;
		end
	end

	assign o_thermal_shutdown_force    = test_r[poe_ctl_pkg::TST_TSD_FORCE];
	assign o_disc_timer_disable        = test_r[poe_ctl_pkg::TST_DISC_TMR_OFF];
	assign o_disc_halt                 = test_r[poe_ctl_pkg::TST_DISC_HALT];
	assign o_dc_disc_timer_zero        = test_r[poe_ctl_pkg::TST_DC_TMR_ZERO];
	assign o_error_delay_timer_disable = test_r[poe_ctl_pkg::TST_ERR_TMR_OFF];

////////////////////////////////////////////////////////////////////////////////
// Common control register.

	logic [7:0] common_r;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			common_r <= poe_ctl_pkg::RESET_VALUE;
		end else if (clr) begin
			common_r <= poe_ctl_pkg::RESET_VALUE;
		end else if (wr_common) begin
			common_r <= i_wr_data & poe_ctl_pkg::CC_MASK;
			// Once probed, the thermal fault disable keeps its value.
			if (i_device_probed) begin
				common_r[poe_ctl_pkg::CC_TSD_DISABLE] <=
					common_r[poe_ctl_pkg::CC_TSD_DISABLE];
			end
		end
	end

	assign o_thermal_shutdown_fault_disable = common_r[poe_ctl_pkg::CC_TSD_DISABLE];
	assign o_ac_disconnect_high_drive = common_r[poe_ctl_pkg::CC_AC_HIGH];
	assign o_ac_disconnect_low_drive  = common_r[poe_ctl_pkg::CC_AC_LOW];
	assign o_uvov_fault_disable       = common_r[poe_ctl_pkg::CC_UVOV_DISABLE];
	assign o_all_ports_off            = common_r[poe_ctl_pkg::CC_ALL_OFF];

////////////////////////////////////////////////////////////////////////////////
// Per-port registers.

	logic [5:0]           func_r [NUM_PORTS];
	logic [NUM_PORTS-1:0] pdis_r;
	logic [NUM_PORTS-1:0] abort_r;
	logic [NUM_PORTS-1:0] start_r;
	logic [NUM_PORTS-1:0] fstart_r;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic hit;
		assign hit = port_sel == 2'(p);

		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				func_r[p]   <= '0;
				fstart_r[p] <= 1'b0;
			end else if (clr) begin
				func_r[p]   <= '0;
				fstart_r[p] <= 1'b0;
			end else begin
				fstart_r[p] <= wr_func && hit;
				if (wr_func && hit) begin
					func_r[p] <= i_wr_data[5:0] & poe_ctl_pkg::PF_MASK[5:0];
				end
			end
		end

		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				pdis_r[p]  <= 1'b0;
				abort_r[p] <= 1'b0;
				start_r[p] <= 1'b0;
			end else if (clr) begin
				pdis_r[p]  <= 1'b0;
				abort_r[p] <= 1'b0;
				start_r[p] <= 1'b0;
			end else if (wr_pen && hit) begin
				pdis_r[p]  <= i_wr_data[poe_ctl_pkg::PE_PORT_DISABLE];
				abort_r[p] <= i_wr_data[poe_ctl_pkg::PE_CONV_ABORT];
				start_r[p] <= i_wr_data[poe_ctl_pkg::PE_CONV_START];
			end else begin
				start_r[p] <= 1'b0;
			end
		end

		assign o_port_function[p*4 +: 4] = func_r[p][3:0];
		assign o_disc_fault_disable[p]    = func_r[p][poe_ctl_pkg::PF_DISC_FAULT_OFF];
		assign o_dc_disconnect_disable[p] = func_r[p][poe_ctl_pkg::PF_DC_DISC_OFF];
		// Port is forced off by thermal test, global shutdown, disable, or code zero.
		assign o_port_off[p] = o_thermal_shutdown_force || o_all_ports_off || pdis_r[p]
			|| func_r[p][3:0] == poe_ctl_pkg::FN_DISABLE;
	end

	assign o_function_start = fstart_r;
	assign o_port_disable   = pdis_r;
	assign o_conv_start     = start_r;
	assign o_conv_abort     = abort_r;

////////////////////////////////////////////////////////////////////////////////
// Checks.

	// A second start write in the very next cycle legally keeps the strobe up.
	a_conv_start_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(o_conv_start[0] && !(wr_pen && port_sel == 2'd0 && i_wr_data[3])) |=> !o_conv_start[0])
		else $error("conversion start did not self clear");

	a_conv_start_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_pen && port_sel == 2'd0 && i_wr_data[3] && !clr) |=> o_conv_start[0])
		else $error("conversion start not raised");

	a_sw_reset_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		sw_reset |=> (common_r == 8'h00 && o_por_active && test_r == 8'h00))
		else $error("software reset did not clear");

	a_tsd_lock: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && i_device_probed && !clr) |=>
		$stable(o_thermal_shutdown_fault_disable))
		else $error("thermal disable changed after probe");

	a_tsd_free: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && !i_device_probed && !clr) |=>
		o_thermal_shutdown_fault_disable == $past(i_wr_data[poe_ctl_pkg::CC_TSD_DISABLE]))
		else $error("thermal disable not written before probe");

	a_ac_high_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && !clr) |=> o_ac_disconnect_high_drive == $past(i_wr_data[4]))
		else $error("AC high drive wrong");

	a_ac_low_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && !clr) |=> o_ac_disconnect_low_drive == $past(i_wr_data[3]))
		else $error("AC low drive wrong");

	a_uvov_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && !clr) |=> o_uvov_fault_disable == $past(i_wr_data[2]))
		else $error("voltage fault disable wrong");

	a_all_off_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_common && !clr) |=> o_all_ports_off == $past(i_wr_data[poe_ctl_pkg::CC_ALL_OFF]))
		else $error("global shutdown bit wrong");

	a_tsd_all_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_thermal_shutdown_force |-> o_port_off == '1)
		else $error("thermal test left a port on");

	a_all_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_all_ports_off |-> o_port_off == '1)
		else $error("global shutdown left a port on");

	a_port_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_func && port_sel == 2'd2 && !clr) |=>
		(o_port_function[11:8] == $past(i_wr_data[3:0]) && o_function_start == 4'h4))
		else $error("function write reached wrong port");

	a_port_options: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_func && port_sel == 2'd1 && !clr) |=>
		(o_disc_fault_disable[1] == $past(i_wr_data[poe_ctl_pkg::PF_DISC_FAULT_OFF])
		&& o_dc_disconnect_disable[1] == $past(i_wr_data[poe_ctl_pkg::PF_DC_DISC_OFF])))
		else $error("port fault options wrong");

	a_func_zero_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_func && port_sel == 2'd3 && i_wr_data[3:0] == 4'h0 && !clr) |=>
		(o_port_off[3] && o_port_function[15:12] == 4'h0))
		else $error("code zero left the port powered");

	a_pen_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_pen && port_sel == 2'd0 && !clr) |=>
		(o_port_disable[0] == $past(i_wr_data[poe_ctl_pkg::PE_PORT_DISABLE])
		&& o_conv_abort[0] == $past(i_wr_data[poe_ctl_pkg::PE_CONV_ABORT])))
		else $error("port disable or abort wrong");

	a_por_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(o_por_active && !sw_reset && test_r[5]) |=> !o_por_active)
		else $error("hold bit did not end power-on cycle");

	a_test_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_test && !sw_reset) |=> (o_disc_halt == $past(i_wr_data[3])
		&& o_error_delay_timer_disable == $past(i_wr_data[1])))
		else $error("test register bits wrong");

	a_test_modes: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_test && !sw_reset) |=> (o_thermal_shutdown_force == $past(i_wr_data[6])
		&& o_disc_timer_disable == $past(i_wr_data[4])
		&& o_dc_disc_timer_zero == $past(i_wr_data[2])))
		else $error("test mode bits wrong");

	a_por_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_por_active |-> (common_r == poe_ctl_pkg::RESET_VALUE && o_port_function == '0
		&& o_port_disable == '0 && o_conv_abort == '0))
		else $error("registers not clear during power-on cycle");

	// A function write to the first port with no repeat must give exactly one strobe.
	sequence s_func_wr0;
		wr_func && port_sel == 2'd0 && !clr;
	endsequence

	sequence s_fstart_once0;
		o_function_start[0] ##1 !o_function_start[0];
	endsequence

	a_fstart_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_func_wr0 ##1 !(wr_func && port_sel == 2'd0) |-> s_fstart_once0)
		else $error("function start was not one pulse");
endmodule
`default_nettype wire

// [test/poe_host_model.sv]
// Behavioural host that issues byte writes to the control register bank.
// Assumes its tasks are called from one bench process at a time.
`timescale 1ns/1ns
`default_nettype none
module poe_host_model (
	input  wire logic       i_clk,
	output logic            o_wr_stb,
	output logic [7:0]      o_wr_cmd,
	output logic [7:0]      o_wr_data
);
	initial begin
		o_wr_stb = 1'b0;
		o_wr_cmd = 8'h00;
		o_wr_data = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// The strobe is left up after the rising edge that takes it, until idle() drops it, so calls may run back to back.
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		@(negedge i_clk);
		o_wr_stb <= 1'b1;
		o_wr_cmd <= cmd;
		o_wr_data <= data;
		@(posedge i_clk);
	endtask

	// Released lines show the inverse, so a stale byte is never mistaken for a fresh one.
	task automatic idle();
		@(negedge i_clk);
		o_wr_stb <= 1'b0;
		o_wr_cmd <= ~o_wr_cmd;
		o_wr_data <= ~o_wr_data;
	endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the port control write register bank.
// Assumes a host model drives the write port and the power-on count is shortened.
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int POR_N = 8;
	localparam logic [15:0] ROWS [0:22] = '{16'h082A, 16'h0814, 16'h08C0, 16'h10C1,
		16'h1122, 16'h1233, 16'h1305, 16'h1006, 16'h1117, 16'h1238, 16'h1329, 16'h100A,
		16'h111B, 16'h122C, 16'h1300, 16'h181C, 16'h19E3, 16'h1A1C, 16'h1800, 16'h1A00,
		16'h785E, 16'h78A4, 16'h7881};
	logic        i_clk, i_arst_n, i_device_probed, i_wr_stb;
	logic [7:0]  i_wr_cmd, i_wr_data, cmd, exp_v;
	logic        o_por_active, o_thermal_shutdown_force, o_disc_timer_disable, o_disc_halt;
	logic        o_dc_disc_timer_zero, o_error_delay_timer_disable, o_uvov_fault_disable;
	logic        o_thermal_shutdown_fault_disable, o_ac_disconnect_high_drive;
	logic        o_ac_disconnect_low_drive, o_all_ports_off;
	logic [3:0]  o_port_off, o_function_start, o_disc_fault_disable, o_dc_disconnect_disable;
	logic [3:0]  o_port_disable, o_conv_start, o_conv_abort;
	logic [15:0] o_port_function, fn_exp;
	int          miscompares = 0;
	int          checks_done = 0;
	int          n;

	poe_host_model poe_host_model_inst (.i_clk, .o_wr_stb(i_wr_stb), .o_wr_cmd(i_wr_cmd),
		.o_wr_data(i_wr_data));
	poe_port_control_write_regs #(.POR_CYC(POR_N)) poe_port_control_write_regs_inst (
		.i_clk, .i_arst_n, .i_wr_stb, .i_wr_cmd, .i_wr_data, .i_device_probed,
		.o_por_active, .o_thermal_shutdown_force, .o_disc_timer_disable, .o_disc_halt,
		.o_dc_disc_timer_zero, .o_error_delay_timer_disable, .o_thermal_shutdown_fault_disable,
		.o_ac_disconnect_high_drive, .o_ac_disconnect_low_drive, .o_uvov_fault_disable,
		.o_all_ports_off, .o_port_off, .o_port_function, .o_function_start,
		.o_disc_fault_disable, .o_dc_disconnect_disable, .o_port_disable, .o_conv_start,
		.o_conv_abort);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic put(input logic [7:0] c, input logic [7:0] d);
		poe_host_model_inst.wr(c, d);
		poe_host_model_inst.idle();
		repeat (2) @(negedge i_clk);
	endtask

	task automatic wait_por();
		for (int i = 0; i < POR_N + 8 && o_por_active !== 1'b0; i++) @(negedge i_clk);
		if (o_por_active !== 1'b0) begin
			miscompares++;
			give_verdict();
		end
	endtask

	// A pulse only counts when it is the lone bit of its port, so a stray port shows up.
	task automatic pulses(input logic conv, input int p, output int cnt);
		cnt = 0;
		for (int i = 0; i < 6; i++) begin
			if (i == 0) poe_host_model_inst.idle();
			else @(negedge i_clk);
			cnt += ((conv ? o_conv_start : o_function_start) === 4'(1 << p));
		end
	endtask

	// Rebuilds the written byte image of one register from the outputs.
	function automatic logic [7:0] view(input logic [7:0] c);
		int p = c[1:0];
		case (c[6:3])
			4'h1: view = {2'b00, o_thermal_shutdown_fault_disable, o_ac_disconnect_high_drive,
				o_ac_disconnect_low_drive, o_uvov_fault_disable, o_all_ports_off, 1'b0};
			4'h2: view = {2'b00, o_disc_fault_disable[p], o_dc_disconnect_disable[p],
				o_port_function[4*p+:4]};
			4'h3: view = {3'b000, o_port_disable[p], 1'b0, o_conv_abort[p], 2'b00};
			default: view = {1'b0, o_thermal_shutdown_force, 1'b0, o_disc_timer_disable,
				o_disc_halt, o_dc_disc_timer_zero, o_error_delay_timer_disable, 1'b0};
		endcase
	endfunction

	function automatic logic [7:0] mask(input logic [3:0] sel);
		case (sel)
			4'h1: mask = poe_ctl_pkg::CC_MASK;
			4'h2: mask = poe_ctl_pkg::PF_MASK;
			4'h3: mask = poe_ctl_pkg::PE_MASK;
			default: mask = poe_ctl_pkg::TST_MASK & 8'hDF;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		i_arst_n = 1'b0;
		i_device_probed = 1'b0;
		fn_exp = 16'h0000;
		repeat (12) @(negedge i_clk);
		chk("por_active", 16'h1, o_por_active);
		chk("port_off", 16'hF, o_port_off);
		i_arst_n = 1'b1;
		put(8'h08, 8'h10);
		wait_por();
		chk("ac_high", 16'h0, o_ac_disconnect_high_drive);
		foreach (ROWS[r]) begin
			cmd = ROWS[r][15:8];
			put(cmd, ROWS[r][7:0]);
			exp_v = ROWS[r][7:0] & mask(cmd[6:3]);
			chk("view", exp_v, view(cmd));
			if (cmd[6:3] == 4'h2) fn_exp[4*cmd[1:0]+:4] = ROWS[r][3:0];
			chk("functions", fn_exp, o_port_function);
		end
		// Back-to-back function writes to two ports.
		poe_host_model_inst.wr(8'h10, 8'h01);
		poe_host_model_inst.wr(8'h11, 8'h05);
		pulses(1'b0, 1, n);
		chk("function_start", 16'h1, 16'(n));
		fn_exp[7:0] = 8'h51;
		chk("functions", fn_exp, o_port_function);
		poe_host_model_inst.wr(8'h1A, 8'h0C);
		pulses(1'b1, 2, n);
		chk("conv_start", 16'h1, 16'(n));
		chk("conv_abort", 16'h4, o_conv_abort);
		put(8'h18, 8'h10);
		chk("port_off", 16'h1, o_port_off[0]);
		put(8'h18, 8'h00);
		chk("port_off", 16'h0, o_port_off[0]);
		put(8'h08, 8'h02);
		chk("port_off", 16'hF, o_port_off);
		put(8'h08, 8'h00);
		// Test register writes only pick test modes for checking, never an end use.
		put(8'h78, 8'h40);
		chk("port_off", 16'hF, o_port_off);
		put(8'h78, 8'h00);
		put(8'h10, 8'h00);
		chk("port_off", 16'h1, o_port_off[0]);
		put(8'h08, 8'h20);
		i_device_probed = 1'b1;
		put(8'h08, 8'h10);
		chk("common", 16'h30, view(8'h08));
		put(8'h78, 8'h1E);
		put(8'h08, 8'h01);
		chk("por_active", 16'h1, o_por_active);
		chk("test", 16'h0, view(8'h78));
		chk("common", 16'h0, view(8'h08));
		chk("functions", 16'h0, o_port_function);
		wait_por();
		poe_host_model_inst.wr(8'h08, 8'h01);
		poe_host_model_inst.idle();
		poe_host_model_inst.wr(8'h78, 8'h20);
		poe_host_model_inst.idle();
		@(negedge i_clk);
		chk("por_active", 16'h0, o_por_active);
		i_arst_n = 1'b0;
		@(negedge i_clk);
		chk("por_active", 16'h1, o_por_active);
		give_verdict();
	end
endmodule
`default_nettype wire
